// file: common/event_output_pkg.sv
`default_nettype none

package event_output_pkg;

   // channel layout: 0 and 1 are the extension digital outputs,
   // 2 to 7 are relays one to six
   localparam int N_OUT        = 8;
   localparam int N_DIG        = 2;
   localparam int N_REL        = 6;
   localparam int N_EMBED_REL  = 3;
   localparam int SEL_W        = 6;
   localparam int N_EVENTS     = 64;
   localparam int ACT_W        = 16;
   localparam int HOLD_W       = 14;
   localparam int ADDR_W       = 8;

   // timing
   localparam int CLK_PERIOD_NS  = 10;
   localparam int TICK_PERIOD_NS = 1_000_000;
   localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
   localparam logic [ACT_W-1:0]  ACT_MAX_MS  = 16'hEA60;
   localparam logic [HOLD_W-1:0] HOLD_MAX_MS = 14'h270F;

   // register map
   localparam logic [ADDR_W-1:0] CH_STRIDE  = 8'h10;
   localparam logic [1:0]        FLD_SEL    = 2'h0;
   localparam logic [1:0]        FLD_ACT    = 2'h1;
   localparam logic [1:0]        FLD_LEVEL  = 2'h2;
   localparam logic [1:0]        FLD_HOLD   = 2'h3;
   localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h80;
   localparam int STAT_OUT_LSB    = 0;
   localparam int STAT_EXT_BIT    = 8;
   localparam int STAT_RELOPT_BIT = 9;
   localparam int STAT_EVT_LSB    = 16;

   // reset values
   localparam logic [SEL_W-1:0]  RST_SEL   = 6'h00;
   localparam logic [ACT_W-1:0]  RST_ACT   = 16'h0000;
   localparam logic [HOLD_W-1:0] RST_HOLD  = 14'h0000;
   localparam logic              RST_LEVEL = 1'b1;

   // event selection codes
   localparam logic [SEL_W-1:0] EV_NONE       = 6'h00;
   localparam logic [SEL_W-1:0] EV_FAULT      = 6'h01;
   localparam logic [SEL_W-1:0] EV_MAINS      = 6'h02;
   localparam logic [SEL_W-1:0] EV_PRIMING    = 6'h03;
   localparam logic [SEL_W-1:0] EV_JOCKEY     = 6'h04;
   localparam logic [SEL_W-1:0] EV_PUMP_FIRST = 6'h05;
   localparam logic [SEL_W-1:0] EV_PUMP_LAST  = 6'h0A;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [SEL_W-1:0]  sel;
      logic              output_active_level;
      logic [ACT_W-1:0]  output_activation_delay;
      logic [HOLD_W-1:0] output_hold_delay;
   } chan_cfg_s;

endpackage

`default_nettype wire

// file: rtl/output_delay_timer.sv
`default_nettype none

module output_delay_timer #(
   parameter int ACT_W  = 16,
   parameter int HOLD_W = 14
) (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic              ce,
   input  wire logic              tick,
   input  wire logic              enable,
   input  wire logic              event_in,
   input  wire logic [ACT_W-1:0]  act_delay,
   input  wire logic [HOLD_W-1:0] hold_delay,
   output logic                   state_q
);

   logic [ACT_W-1:0] count_q;
   logic [ACT_W-1:0] target;

   assign target = event_in ? act_delay : ACT_W'(hold_delay);

   // first tick may be partial: delay lands between n-1 and n ms
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q <= 1'b0;
         count_q <= '0;
      end else if (ce) begin
         if (!enable) begin
            state_q <= 1'b0;
            count_q <= '0;
         end else if (event_in == state_q) begin
            count_q <= '0; // [RULE_11]
         end else if (target == '0) begin
            state_q <= event_in;
            count_q <= '0;
         end else if (tick) begin
            if (count_q >= target - ACT_W'(1)) begin // [RULE_01] [RULE_03]
               state_q <= event_in;
               count_q <= '0;
            end else begin
               count_q <= count_q + ACT_W'(1); // [RULE_11]
            end
         end
      end
   end

endmodule

`default_nettype wire

// file: rtl/event_output_conditioner.sv
// Implementation choices: the address map and the AXI4-Lite interface to the registers.
`default_nettype none

// Summary of operation
// [RULE_01] output changes only after the activation delay, 0 to 60000 ms
// [RULE_02] both delays of every output reset to zero
// [RULE_03] output returns only after the hold delay, 0 to 9999 ms
// [RULE_04] fault, mains, priming, jockey, pump events force delays to zero
// [RULE_05] high active level drives one while delayed event true; default
// [RULE_06] low active level drives zero while true, one otherwise
// [RULE_07] mains contactor event forces active level high
// [RULE_08] each output has its own event selector from the shared set
// [RULE_09] digital outputs exist only with the extension module present
// [RULE_10] six relays, four to six only with the relay option fitted
// [RULE_11] delays counted on a millisecond tick; reverting event cancels
module event_output_conditioner #(
   parameter int TICK_CYCLES = event_output_pkg::TICK_CYCLES
) (
   input  wire logic                                aclk,
   input  wire logic                                aresetn,
   input  wire logic                                ce,
   input  wire logic [event_output_pkg::N_EVENTS-1:0] event_bus,
   input  wire logic                                ext_io_present,
   input  wire logic                                relay_option_present,
   output logic                                     digital_output_a,
   output logic                                     digital_output_b,
   output logic [event_output_pkg::N_REL-1:0]       relay_out,
   input  wire logic [event_output_pkg::ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                                s_axi_awvalid,
   output logic                                     s_axi_awready,
   input  wire logic [31:0]                         s_axi_wdata,
   input  wire logic [3:0]                          s_axi_wstrb,
   input  wire logic                                s_axi_wvalid,
   output logic                                     s_axi_wready,
   output logic [1:0]                               s_axi_bresp,
   output logic                                     s_axi_bvalid,
   input  wire logic                                s_axi_bready,
   input  wire logic [event_output_pkg::ADDR_W-1:0] s_axi_araddr,
   input  wire logic                                s_axi_arvalid,
   output logic                                     s_axi_arready,
   output logic [31:0]                              s_axi_rdata,
   output logic [1:0]                               s_axi_rresp,
   output logic                                     s_axi_rvalid,
   input  wire logic                                s_axi_rready
);

   localparam int N_OUT  = event_output_pkg::N_OUT;
   localparam int ACT_W  = event_output_pkg::ACT_W;
   localparam int HOLD_W = event_output_pkg::HOLD_W;
   localparam int SEL_W  = event_output_pkg::SEL_W;
   localparam int ADDR_W = event_output_pkg::ADDR_W;
   localparam int TICK_W = $clog2(TICK_CYCLES + 1);

   event_output_pkg::chan_cfg_s cfg_q [N_OUT];
   logic [N_OUT-1:0]  present;
   logic [N_OUT-1:0]  forced_zero;
   logic [N_OUT-1:0]  sel_event;
   logic [N_OUT-1:0]  delayed_q;
   logic [N_OUT-1:0]  eff_level;
   logic [N_OUT-1:0]  out_q;
   logic [2:0]        ext_sync_q;
   logic [2:0]        relopt_sync_q;
   logic              ext_present_q;
   logic              relopt_present_q;
   logic [TICK_W-1:0] tick_cnt_q;
   logic              tick_q;

   logic [ADDR_W-1:0] awaddr_q;
   logic [31:0]       wdata_q;
   logic [3:0]        wstrb_q;
   logic              aw_full_q;
   logic              w_full_q;
   logic              do_write;
   logic [31:0]       wr_mask;
   logic [31:0]       wr_value;

   function automatic logic forced_sel(input logic [SEL_W-1:0] s);
      forced_sel = (s == event_output_pkg::EV_FAULT)
                || (s == event_output_pkg::EV_MAINS)
                || (s == event_output_pkg::EV_PRIMING)
                || (s == event_output_pkg::EV_JOCKEY)
                || ((s >= event_output_pkg::EV_PUMP_FIRST)
                    && (s <= event_output_pkg::EV_PUMP_LAST));
   endfunction

   // decoded address: channel index, field, and whether it maps at all
   function automatic logic addr_is_chan(input logic [ADDR_W-1:0] a);
      addr_is_chan = (a[ADDR_W-1] == 1'b0) && (a[1:0] == 2'h0);
   endfunction

   function automatic logic addr_ok(input logic [ADDR_W-1:0] a,
                                    input logic [N_OUT-1:0]  pres);
      if (a == event_output_pkg::OFF_STATUS) begin
         addr_ok = 1'b1;
      end else if (addr_is_chan(a)) begin
         addr_ok = pres[a[6:4]]; // [RULE_09] [RULE_10]
      end else begin
         addr_ok = 1'b0;
      end
   endfunction

   // presence straps come from pins: three stages, change once 2 and 3 agree
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ext_sync_q       <= 3'h0;
         relopt_sync_q    <= 3'h0;
         ext_present_q    <= 1'b0;
         relopt_present_q <= 1'b0;
      end else if (ce) begin
         ext_sync_q    <= {ext_sync_q[1:0], ext_io_present};
         relopt_sync_q <= {relopt_sync_q[1:0], relay_option_present};
         if (ext_sync_q[2] == ext_sync_q[1]) begin
            ext_present_q <= ext_sync_q[2];
         end
         if (relopt_sync_q[2] == relopt_sync_q[1]) begin
            relopt_present_q <= relopt_sync_q[2];
         end
      end
   end

   always_comb begin
      for (int i = 0; i < N_OUT; i++) begin
         if (i < event_output_pkg::N_DIG) begin
            present[i] = ext_present_q; // [RULE_09]
         end else if (i < event_output_pkg::N_DIG
                          + event_output_pkg::N_EMBED_REL) begin
            present[i] = 1'b1; // [RULE_10]
         end else begin
            present[i] = relopt_present_q; // [RULE_10]
         end
      end
   end

   // millisecond tick
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tick_cnt_q <= '0;
         tick_q     <= 1'b0;
      end else if (ce) begin
         if (tick_cnt_q == TICK_W'(TICK_CYCLES - 1)) begin
            tick_cnt_q <= '0;
            tick_q     <= 1'b1; // [RULE_11]
         end else begin
            tick_cnt_q <= tick_cnt_q + TICK_W'(1);
            tick_q     <= 1'b0;
         end
      end
   end

   always_comb begin
      for (int i = 0; i < N_OUT; i++) begin
         forced_zero[i] = forced_sel(cfg_q[i].sel); // [RULE_04]
         sel_event[i]   = (cfg_q[i].sel != event_output_pkg::EV_NONE)
                        && event_bus[cfg_q[i].sel]; // [RULE_08]
         eff_level[i]   = (cfg_q[i].sel == event_output_pkg::EV_MAINS)
                        || cfg_q[i].output_active_level; // [RULE_07]
      end
   end

   for (genvar g = 0; g < N_OUT; g++) begin : g_chan
      output_delay_timer #(
         .ACT_W  (ACT_W),
         .HOLD_W (HOLD_W)
      ) u_timer (
         .aclk       (aclk),
         .aresetn    (aresetn),
         .ce         (ce),
         .tick       (tick_q),
         .enable     (present[g]),
         .event_in   (sel_event[g]),
         .act_delay  (forced_zero[g] ? '0
                                     : cfg_q[g].output_activation_delay),
         .hold_delay (forced_zero[g] ? '0
                                     : cfg_q[g].output_hold_delay),
         .state_q    (delayed_q[g])
      );
   end

   // absent outputs stay de-energised
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         out_q <= '0;
      end else if (ce) begin
         for (int i = 0; i < N_OUT; i++) begin
            out_q[i] <= present[i]
                      && (eff_level[i] ? delayed_q[i]     // [RULE_05]
                                       : !delayed_q[i]);  // [RULE_06]
         end
      end
   end

   assign digital_output_a = out_q[0];
   assign digital_output_b = out_q[1];
   assign relay_out        = out_q[N_OUT-1:event_output_pkg::N_DIG];

   function automatic logic [31:0] reg_value(input logic [ADDR_W-1:0] a);
      logic [2:0] ch;
      ch = a[6:4];
      reg_value = 32'h0000_0000;
      if (a == event_output_pkg::OFF_STATUS) begin
         reg_value[event_output_pkg::STAT_OUT_LSB +: N_OUT] = out_q;
         reg_value[event_output_pkg::STAT_EXT_BIT]    = ext_present_q;
         reg_value[event_output_pkg::STAT_RELOPT_BIT] = relopt_present_q;
         reg_value[event_output_pkg::STAT_EVT_LSB +: N_OUT] = delayed_q;
      end else if (addr_is_chan(a)) begin
         unique case (a[3:2])
            event_output_pkg::FLD_SEL:
               reg_value[SEL_W-1:0] = cfg_q[ch].sel;
            event_output_pkg::FLD_ACT:
               reg_value[ACT_W-1:0] = cfg_q[ch].output_activation_delay;
            event_output_pkg::FLD_LEVEL:
               reg_value[0] = cfg_q[ch].output_active_level;
            event_output_pkg::FLD_HOLD:
               reg_value[HOLD_W-1:0] = cfg_q[ch].output_hold_delay;
         endcase
      end
   endfunction

   // write channels: address and data taken in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_q     <= 1'b0;
         s_axi_awready <= 1'b0;
         awaddr_q      <= '0;
      end else if (ce) begin
         if (s_axi_awready && s_axi_awvalid) begin
            aw_full_q     <= 1'b1;
            s_axi_awready <= 1'b0;
            awaddr_q      <= s_axi_awaddr;
         end else if (s_axi_bvalid && s_axi_bready) begin
            aw_full_q     <= 1'b0;
            s_axi_awready <= 1'b1;
         end else if (!aw_full_q) begin
            s_axi_awready <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_full_q     <= 1'b0;
         s_axi_wready <= 1'b0;
         wdata_q      <= '0;
         wstrb_q      <= '0;
      end else if (ce) begin
         if (s_axi_wready && s_axi_wvalid) begin
            w_full_q     <= 1'b1;
            s_axi_wready <= 1'b0;
            wdata_q      <= s_axi_wdata;
            wstrb_q      <= s_axi_wstrb;
         end else if (s_axi_bvalid && s_axi_bready) begin
            w_full_q     <= 1'b0;
            s_axi_wready <= 1'b1;
         end else if (!w_full_q) begin
            s_axi_wready <= 1'b1;
         end
      end
   end

   assign do_write = aw_full_q && w_full_q && !s_axi_bvalid;

   always_comb begin
      for (int b = 0; b < 4; b++) begin
         wr_mask[8*b +: 8] = {8{wstrb_q[b]}};
      end
      wr_value = (reg_value(awaddr_q) & ~wr_mask) | (wdata_q & wr_mask);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= event_output_pkg::RESP_OKAY;
      end else if (ce) begin
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= addr_ok(awaddr_q, present)
                          ? event_output_pkg::RESP_OKAY
                          : event_output_pkg::RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // configuration store; absent channels ignore writes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < N_OUT; i++) begin
            cfg_q[i].sel                     <= event_output_pkg::RST_SEL;
            cfg_q[i].output_active_level     <= event_output_pkg::RST_LEVEL;
            cfg_q[i].output_activation_delay <= event_output_pkg::RST_ACT;
            cfg_q[i].output_hold_delay       <= event_output_pkg::RST_HOLD;
         end // [RULE_02] [RULE_05]
      end else if (ce && do_write && addr_is_chan(awaddr_q)
                   && present[awaddr_q[6:4]]) begin
         unique case (awaddr_q[3:2])
            event_output_pkg::FLD_SEL: begin
               cfg_q[awaddr_q[6:4]].sel <= wr_value[SEL_W-1:0]; // [RULE_08]
               if (forced_sel(wr_value[SEL_W-1:0])) begin
                  cfg_q[awaddr_q[6:4]].output_activation_delay <= '0;
                  cfg_q[awaddr_q[6:4]].output_hold_delay <= '0; // [RULE_04]
               end
            end
            event_output_pkg::FLD_ACT: begin
               // out-of-range values saturate at the top of the range
               if (!forced_zero[awaddr_q[6:4]]) begin // [RULE_04]
                  cfg_q[awaddr_q[6:4]].output_activation_delay <=
                     (wr_value[31:0] > 32'(event_output_pkg::ACT_MAX_MS))
                     ? event_output_pkg::ACT_MAX_MS
                     : wr_value[ACT_W-1:0]; // [RULE_01]
               end
            end
            event_output_pkg::FLD_LEVEL: begin
               cfg_q[awaddr_q[6:4]].output_active_level <= wr_value[0];
            end
            event_output_pkg::FLD_HOLD: begin
               if (!forced_zero[awaddr_q[6:4]]) begin // [RULE_04]
                  cfg_q[awaddr_q[6:4]].output_hold_delay <=
                     (wr_value[31:0] > 32'(event_output_pkg::HOLD_MAX_MS))
                     ? event_output_pkg::HOLD_MAX_MS
                     : wr_value[HOLD_W-1:0]; // [RULE_03]
               end
            end
         endcase
      end
   end

   // read channel: one cycle from address to data
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= event_output_pkg::RESP_OKAY;
      end else if (ce) begin
         if (s_axi_arready && s_axi_arvalid) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            if (addr_ok(s_axi_araddr, present)) begin
               s_axi_rdata <= reg_value(s_axi_araddr);
               s_axi_rresp <= event_output_pkg::RESP_OKAY;
            end else begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= event_output_pkg::RESP_SLVERR;
            end
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
         end
      end
   end

endmodule

`default_nettype wire

// file: testbench/event_output_conditioner_props.sv
`default_nettype none

module event_output_conditioner_props (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        ce,
   input wire logic        ext_io_present,
   input wire logic        relay_option_present,
   input wire logic        digital_output_a,
   input wire logic        digital_output_b,
   input wire logic [5:0]  relay_out,
   input wire logic [7:0]  s_axi_awaddr,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [7:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // unaligned or past the status word
   function automatic logic bad(logic [7:0] a);
      return a[1:0] != 2'h0 || a > 8'h80;
   endfunction

   sequence ar_take;
      ce && s_axi_arvalid && s_axi_arready;
   endsequence
   sequence wr_take;
      ce && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence

   rd_answer_a: assert property (ar_take |=> s_axi_rvalid)
      else $error("read not answered one cycle after address");
   rd_unmapped_a: assert property (ar_take ##0 bad(s_axi_araddr) |=>
      s_axi_rresp == event_output_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
      else $error("bad read address not refused");
   wr_answer_a: assert property (wr_take ##1 ce |=> s_axi_bvalid)
      else $error("write response late");
   wr_refuse_a: assert property (wr_take |=>
      (!s_axi_awready && !s_axi_wready) [*2])
      else $error("write channels ready while write pending");
   wr_unmapped_a: assert property (wr_take ##0 bad(s_axi_awaddr) ##1 ce
      |=> s_axi_bvalid && s_axi_bresp == event_output_pkg::RESP_SLVERR)
      else $error("bad write address not refused");
   b_release_a: assert property (ce && s_axi_bvalid && s_axi_bready |=>
      !s_axi_bvalid && s_axi_awready && s_axi_wready)
      else $error("write channel not freed after response");
   r_release_a: assert property (ce && s_axi_rvalid && s_axi_rready |=>
      !s_axi_rvalid && s_axi_arready)
      else $error("read channel not freed after response");
   dig_absent_a: assert property (
      (ce && !ext_io_present) [*8] |-> !digital_output_a && !digital_output_b)
      else $error("digital outputs driven while module absent");
   relay_absent_a: assert property (
      (ce && !relay_option_present) [*8] |-> relay_out[5:3] == 3'h0)
      else $error("optional relays driven while option absent");
   ce_freeze_a: assert property (!ce |=>
      $stable({relay_out, digital_output_b, digital_output_a}))
      else $error("outputs moved while clock enable low");
endmodule

bind event_output_conditioner event_output_conditioner_props u_props (
   .aclk, .aresetn, .ce, .ext_io_present, .relay_option_present,
   .digital_output_a, .digital_output_b, .relay_out, .s_axi_awaddr,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
   .s_axi_rvalid, .s_axi_rready);

`default_nettype wire

// file: testbench/relay_load_model.sv
`default_nettype none

module relay_load_model (
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic [7:0] coil,
   output logic      [7:0] contact_q
);
   timeunit 1ns;
   timeprecision 1ps;
   // contacts follow coils one clock late; real pull-in time would
   // only stretch the run
   always_ff @(posedge aclk) begin
      if (!aresetn) contact_q <= 8'h00;
      else contact_q <= coil;
   end
endmodule

`default_nettype wire

// file: testbench/event_output_conditioner_tb.sv
`default_nettype none

module event_output_conditioner_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TICK = 10;
   localparam logic [1:0] OK = event_output_pkg::RESP_OKAY;
   localparam logic [1:0] ERR = event_output_pkg::RESP_SLVERR;
   logic        aclk, aresetn, ce, ext_io_present, relay_option_present;
   logic [63:0] event_bus;
   logic        digital_output_a, digital_output_b;
   logic [5:0]  relay_out;
   logic [7:0]  s_axi_awaddr, s_axi_araddr, pins, contacts;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready;
   int          num_errors = 0;
   int          checked = 0;
   int          n;

   assign pins = {relay_out, digital_output_b, digital_output_a};

   event_output_conditioner #(.TICK_CYCLES(TICK)) uut (.aclk, .aresetn,
      .ce, .event_bus, .ext_io_present, .relay_option_present,
      .digital_output_a, .digital_output_b, .relay_out, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

   relay_load_model loads (.aclk, .aresetn, .coil(pins),
      .contact_q(contacts));

   task automatic chk(logic [31:0] seen, logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   task automatic stop_test;
      if (num_errors == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   function automatic logic [7:0] ra(int ch, int f);
      return 8'(ch * 16 + f * 4);
   endfunction

   task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] er);
      int k;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (k = 0; k < 50; k++) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      s_axi_bready <= 1'b0;
      if (k == 50) begin
         chk(0, 1);
         stop_test;
      end
      chk(32'(s_axi_bresp), 32'(er));
   endtask

   task automatic rd(logic [7:0] a, logic [31:0] ed, logic [1:0] er);
      int k;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (k = 0; k < 50; k++) begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      s_axi_rready <= 1'b0;
      if (k == 50) begin
         chk(0, 1);
         stop_test;
      end
      chk(s_axi_rdata, ed);
      chk(32'(s_axi_rresp), 32'(er));
   endtask

   task automatic ev(int code, logic v);
      @(posedge aclk);
      event_bus[code] <= v;
   endtask

   // settled sampling, so counts are edges after the event changed
   task automatic wait_pin(int ch, logic v, int lim, output int cnt);
      cnt = 0;
      while (pins[ch] !== v && cnt < lim) begin
         @(posedge aclk);
         #1;
         cnt++;
      end
   endtask

   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   initial begin
      aresetn = 1'b0;
      ce = 1'b1;
      ext_io_present = 1'b1;
      relay_option_present = 1'b1;
      event_bus = '0;
      s_axi_awaddr = 8'h00;
      s_axi_araddr = 8'h00;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hF;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
      {s_axi_arvalid, s_axi_rready} = 2'h0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (10) @(posedge aclk);
      for (int c = 0; c < 8; c++) begin
         rd(ra(c, 0), 0, OK);
         rd(ra(c, 1), 0, OK);
         rd(ra(c, 2), 1, OK);
         rd(ra(c, 3), 0, OK);
      end
      chk(pins, 0);
      rd(8'h84, 0, ERR);
      rd(8'h25, 0, ERR);
      wr(8'h84, 32'h1, ERR);
      wr(ra(2, 0), 11, OK);
      wr(ra(2, 1), 3, OK);
      wr(ra(2, 3), 2, OK);
      ev(11, 1);
      repeat (8) @(posedge aclk);
      ev(11, 0);
      wait_pin(2, 1, 40, n);
      chk(n, 40);
      ev(11, 1);
      wait_pin(2, 1, 60, n);
      chk(32'(n inside {[20:34]}), 1);
      ev(11, 0);
      wait_pin(2, 0, 60, n);
      chk(32'(n inside {[10:24]}), 1);
      wr(ra(3, 0), 12, OK);
      wr(ra(3, 2), 0, OK);
      wait_pin(3, 1, 10, n);
      chk(pins[3], 1);
      ev(12, 1);
      wait_pin(3, 0, 10, n);
      chk(n, 2);
      for (int k = 1; k <= 10; k++) begin
         wr(ra(4, 0), k, OK);
         wr(ra(4, 1), 5, OK);
         rd(ra(4, 1), 0, OK);
         wr(ra(4, 3), 5, OK);
         rd(ra(4, 3), 0, OK);
      end
      wr(ra(4, 0), 2, OK);
      wr(ra(4, 2), 0, OK);
      repeat (3) @(posedge aclk);
      chk(pins[4], 0);
      ev(2, 1);
      wait_pin(4, 1, 10, n);
      chk(n, 2);
      wr(ra(6, 1), 32'hFFFF, OK);
      rd(ra(6, 1), 32'hEA60, OK);
      wr(ra(6, 3), 32'h3FFF, OK);
      rd(ra(6, 3), 32'h270F, OK);
      // lane 1 only: the low byte keeps its old value
      s_axi_wstrb <= 4'h2;
      wr(ra(6, 3), 32'h0000_0100, OK);
      s_axi_wstrb <= 4'hF;
      rd(ra(6, 3), 32'h010F, OK);
      wr(ra(6, 0), 3, OK);
      rd(ra(6, 1), 0, OK);
      rd(ra(6, 3), 0, OK);
      wr(ra(0, 0), 14, OK);
      wr(ra(7, 0), 14, OK);
      ev(14, 1);
      repeat (4) @(posedge aclk);
      chk({pins[7], pins[0]}, 2'h3);
      ext_io_present <= 1'b0;
      relay_option_present <= 1'b0;
      repeat (10) @(posedge aclk);
      chk(pins[1:0], 0);
      chk(pins[7], 0);
      rd(ra(0, 0), 0, ERR);
      rd(ra(7, 0), 0, ERR);
      rd(ra(2, 0), 11, OK);
      ext_io_present <= 1'b1;
      relay_option_present <= 1'b1;
      repeat (10) @(posedge aclk);
      chk(pins[0], 1);
      rd(8'h80, 32'h0099_0391, OK);
      // frozen by clock enable: the event drop must wait for ce
      ce <= 1'b0;
      ev(14, 0);
      repeat (20) @(posedge aclk);
      chk(pins[0], 1);
      ce <= 1'b1;
      repeat (4) @(posedge aclk);
      chk(pins[0], 0);
      chk(contacts, pins);
      stop_test;
   end
endmodule

`default_nettype wire
